// [core/timer_io_pkg.sv]
// Constants for the channel 0 register B / D I/O control block.
// Assumes a 32-bit classic Wishbone slave port and a 16-bit channel 0 counter.
//------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------
// Summary of operation
// - 8-bit low I/O control register, D in upper nibble, C lower, RW, reset zero.
// - Nibble top bit clear means output compare, set means input capture.
// - Low bits 00 disable pin output; otherwise bit two gives initial level.
// - Compare match drives pin low for 01, high for 10, toggles for 11.
// - Nibble 1000 captures counter on rising edge of the register's own pin.
// - Nibble 1001 captures counter on falling edge of the register's own pin.
// - Nibble 101x captures counter on both edges of the register's own pin.
// - Nibble 11xx on B and D captures on each channel 1 count event.
// - Channel 1 prescale select 000 suppresses that channel-1-count capture.
// - Buffer operation B makes register D ignore its nibble: no capture, no compare.
// - Register D nibble uses the same encodings as B, on its own pin.
// - Initial pin level is applied only while the counter run bit is clear.
package timer_io_pkg;

  //----------------------------------------------------------------------
  // Register byte offsets
  //----------------------------------------------------------------------
  localparam logic [7:0] OFF_IO_CTRL_HIGH = 8'h00; // B nibble upper, A lower
  localparam logic [7:0] OFF_IO_CTRL_LOW  = 8'h04; // D nibble upper, C lower
  localparam logic [7:0] OFF_CONTROL      = 8'h08; // run, buffer, prescale
  localparam logic [7:0] OFF_STATUS       = 8'h0C; // read only pin state
  localparam logic [7:0] OFF_GREG_B       = 8'h10;
  localparam logic [7:0] OFF_GREG_D       = 8'h14;

  //----------------------------------------------------------------------
  // Field positions
  //----------------------------------------------------------------------
  localparam int CTL_RUN_BIT    = 0;  // counter_run_bit
  localparam int CTL_BUFB_BIT   = 1;  // buffer_op_b
  localparam int CTL_PSC_LSB    = 2;  // ch1_prescale_sel, 3 bits
  localparam int NIB_HI_LSB     = 4;
  localparam int STAT_LVL_B     = 0;
  localparam int STAT_LVL_D     = 1;
  localparam int STAT_DRV_B     = 2;
  localparam int STAT_DRV_D     = 3;
  localparam int STAT_PIN_B     = 4;
  localparam int STAT_PIN_D     = 5;

  //----------------------------------------------------------------------
  // Widths, reset values and codes
  //----------------------------------------------------------------------
  localparam int GREG_W = 16;
  localparam logic [7:0]        IO_CTRL_RESET = 8'h00;
  localparam logic [4:0]        CONTROL_RESET = 5'h00;
  localparam logic [GREG_W-1:0] GREG_RESET    = 16'h0000;
  localparam logic [2:0]        PSC_UNDIVIDED = 3'h0;
  localparam logic [1:0]        ACT_LOW       = 2'h1;
  localparam logic [1:0]        ACT_HIGH      = 2'h2;
  localparam logic [1:0]        ACT_TOGGLE    = 2'h3;
  localparam logic [3:0]        NIB_CAP_RISE  = 4'h8;
  localparam logic [3:0]        NIB_CAP_FALL  = 4'h9;
  localparam logic [2:0]        NIB_CAP_BOTH  = 3'h5; // top three bits
  localparam logic [1:0]        NIB_CAP_CH1   = 2'h3; // top two bits

endpackage : timer_io_pkg

// [core/timer_io_control_ch0_bd.sv]
// Channel 0 general register B and D function decode, compare outputs and captures.
// Assumes counter value and count strobes arrive from logic on clock_i; pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none

module timer_io_control_ch0_bd
  import timer_io_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [GREG_W-1:0] ch0_count_i,
  input  wire logic              ch0_count_tick_i,
  input  wire logic              ch1_count_tick_i,
  input  wire logic              ch0_pin_b_i,
  output logic                   ch0_pin_b_o,
  output logic                   ch0_pin_b_oe_n_o,
  input  wire logic              ch0_pin_d_i,
  output logic                   ch0_pin_d_o,
  output logic                   ch0_pin_d_oe_n_o
);

  //----------------------------------------------------------------------
  // Decode helpers shared by registers B and D
  //----------------------------------------------------------------------
  // Output compare with pin drive enabled
  function automatic logic drives_pin(input logic [3:0] nib);
    drives_pin = !nib[3] && (nib[1:0] != 2'h0);
  endfunction : drives_pin

  // Capture request from the nibble and the three possible sources
  function automatic logic capture_hit(input logic [3:0] nib, input logic rise,
                                       input logic fall, input logic ch1_evt);
    capture_hit = (nib == NIB_CAP_RISE && rise)
               || (nib == NIB_CAP_FALL && fall)
               || (nib[3:1] == NIB_CAP_BOTH && (rise || fall))
               || (nib[3:2] == NIB_CAP_CH1 && ch1_evt);
  endfunction : capture_hit

  // Level after a compare match for the given action code
  function automatic logic match_level(input logic [1:0] act, input logic cur);
    case (act)
      ACT_LOW:    match_level = 1'b0;
      ACT_HIGH:   match_level = 1'b1;
      ACT_TOGGLE: match_level = !cur;
      default:    match_level = cur;
    endcase
  endfunction : match_level

  //----------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------
  logic                 ack_r,      ack_nxt;
  logic [31:0]          rdat_r,     rdat_nxt;
  logic [7:0]           io_high_r,  io_high_nxt;
  logic [7:0]           io_low_r,   io_low_nxt;
  logic [4:0]           control_r,  control_nxt;
  logic [GREG_W-1:0]    greg_b_r,   greg_b_nxt;
  logic [GREG_W-1:0]    greg_d_r,   greg_d_nxt;
  logic                 b_s1_r, b_s2_r, b_s3_r;
  logic                 d_s1_r, d_s2_r, d_s3_r;
  logic                 lvl_b_r,    lvl_b_nxt;
  logic                 lvl_d_r,    lvl_d_nxt;
  logic                 oen_b_r,    oen_b_nxt;
  logic                 oen_d_r,    oen_d_nxt;

  logic [3:0]           nib_b;
  logic [3:0]           nib_d;
  logic                 run;
  logic                 buf_b;
  logic                 ch1_evt;
  logic                 rise_b, fall_b, rise_d, fall_d;
  logic                 drive_b, drive_d;
  logic                 match_b, match_d;
  logic                 cap_b, cap_d;
  logic                 wr_cycle;
  logic [7:0]           adr_word;

  //----------------------------------------------------------------------
  // Decoded controls
  //----------------------------------------------------------------------
  // Field views and the compare and capture events
  assign nib_b    = io_high_r[7:NIB_HI_LSB];
  assign nib_d    = io_low_r[7:NIB_HI_LSB];
  assign run      = control_r[CTL_RUN_BIT];
  assign buf_b    = control_r[CTL_BUFB_BIT];
  // An undivided channel 1 clock would fire every cycle, so it is refused
  assign ch1_evt  = ch1_count_tick_i
                 && (control_r[CTL_PSC_LSB+2:CTL_PSC_LSB] != PSC_UNDIVIDED);
  assign rise_b   = b_s2_r && !b_s3_r;
  assign fall_b   = !b_s2_r && b_s3_r;
  assign rise_d   = d_s2_r && !d_s3_r;
  assign fall_d   = !d_s2_r && d_s3_r;
  assign drive_b  = drives_pin(nib_b);
  assign drive_d  = drives_pin(nib_d) && !buf_b;
  assign match_b  = run && ch0_count_tick_i && !nib_b[3] && (ch0_count_i == greg_b_r);
  assign match_d  = run && ch0_count_tick_i && !nib_d[3] && !buf_b && (ch0_count_i == greg_d_r);
  assign cap_b    = capture_hit(nib_b, rise_b, fall_b, ch1_evt);
  assign cap_d    = !buf_b && capture_hit(nib_d, rise_d, fall_d, ch1_evt);
  // Write lands on the edge at which the master sees ack
  assign wr_cycle = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
  assign adr_word = {wb_adr_i[7:2], 2'h0};

  //----------------------------------------------------------------------
  // Wishbone answer
  //----------------------------------------------------------------------
  // One wait state; unmapped reads return zero and still ack
  always_comb begin
    ack_nxt  = wb_cyc_i && wb_stb_i && !ack_r;
    rdat_nxt = 32'h0000_0000;
    if (adr_word == OFF_IO_CTRL_HIGH) begin
      rdat_nxt[7:0] = io_high_r;
    end else if (adr_word == OFF_IO_CTRL_LOW) begin
      rdat_nxt[7:0] = io_low_r;
    end else if (adr_word == OFF_CONTROL) begin
      rdat_nxt[4:0] = control_r;
    end else if (adr_word == OFF_STATUS) begin
      rdat_nxt[STAT_LVL_B] = lvl_b_r;
      rdat_nxt[STAT_LVL_D] = lvl_d_r;
      rdat_nxt[STAT_DRV_B] = !oen_b_r;
      rdat_nxt[STAT_DRV_D] = !oen_d_r;
      rdat_nxt[STAT_PIN_B] = b_s2_r;
      rdat_nxt[STAT_PIN_D] = d_s2_r;
    end else if (adr_word == OFF_GREG_B) begin
      rdat_nxt[GREG_W-1:0] = greg_b_r;
    end else if (adr_word == OFF_GREG_D) begin
      rdat_nxt[GREG_W-1:0] = greg_d_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  //----------------------------------------------------------------------
  // Software registers and general registers
  //----------------------------------------------------------------------
  // Captures override a software write in the same cycle
  always_comb begin
    io_high_nxt = io_high_r;
    io_low_nxt  = io_low_r;
    control_nxt = control_r;
    greg_b_nxt  = greg_b_r;
    greg_d_nxt  = greg_d_r;
    if (wr_cycle) begin
      if (adr_word == OFF_IO_CTRL_HIGH && wb_sel_i[0]) begin
        io_high_nxt = wb_dat_i[7:0];
      end else if (adr_word == OFF_IO_CTRL_LOW && wb_sel_i[0]) begin
        io_low_nxt = wb_dat_i[7:0];
      end else if (adr_word == OFF_CONTROL && wb_sel_i[0]) begin
        control_nxt = wb_dat_i[4:0];
      end else if (adr_word == OFF_GREG_B) begin
        if (wb_sel_i[0]) greg_b_nxt[7:0]  = wb_dat_i[7:0];
        if (wb_sel_i[1]) greg_b_nxt[15:8] = wb_dat_i[15:8];
      end else if (adr_word == OFF_GREG_D) begin
        if (wb_sel_i[0]) greg_d_nxt[7:0]  = wb_dat_i[7:0];
        if (wb_sel_i[1]) greg_d_nxt[15:8] = wb_dat_i[15:8];
      end
    end
    // In buffer mode D shadows B: old B moves to D on capture, D reloads B on match
    if (cap_b) begin
      greg_b_nxt = ch0_count_i;
      if (buf_b) greg_d_nxt = greg_b_r;
    end else if (match_b && buf_b) begin
      greg_b_nxt = greg_d_r;
    end
    if (cap_d) begin
      greg_d_nxt = ch0_count_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      io_high_r <= IO_CTRL_RESET;
      io_low_r  <= IO_CTRL_RESET;
      control_r <= CONTROL_RESET;
      greg_b_r  <= GREG_RESET;
      greg_d_r  <= GREG_RESET;
    end else begin
      io_high_r <= io_high_nxt;
      io_low_r  <= io_low_nxt;
      control_r <= control_nxt;
      greg_b_r  <= greg_b_nxt;
      greg_d_r  <= greg_d_nxt;
    end
  end

  //----------------------------------------------------------------------
  // Pin sampling and pin drive
  //----------------------------------------------------------------------
  // Initial level only while stopped; while running only a match moves it
  always_comb begin
    lvl_b_nxt = lvl_b_r;
    lvl_d_nxt = lvl_d_r;
    oen_b_nxt = !drive_b;
    oen_d_nxt = !drive_d;
    if (!run) begin
      if (drive_b) lvl_b_nxt = nib_b[2];
      if (drive_d) lvl_d_nxt = nib_d[2];
    end else begin
      if (match_b) lvl_b_nxt = match_level(nib_b[1:0], lvl_b_r);
      if (match_d) lvl_d_nxt = match_level(nib_d[1:0], lvl_d_r);
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      b_s1_r  <= 1'b0;
      b_s2_r  <= 1'b0;
      b_s3_r  <= 1'b0;
      d_s1_r  <= 1'b0;
      d_s2_r  <= 1'b0;
      d_s3_r  <= 1'b0;
      lvl_b_r <= 1'b0;
      lvl_d_r <= 1'b0;
      oen_b_r <= 1'b1;
      oen_d_r <= 1'b1;
    end else begin
      b_s1_r  <= ch0_pin_b_i;
      b_s2_r  <= b_s1_r;
      b_s3_r  <= b_s2_r;
      d_s1_r  <= ch0_pin_d_i;
      d_s2_r  <= d_s1_r;
      d_s3_r  <= d_s2_r;
      lvl_b_r <= lvl_b_nxt;
      lvl_d_r <= lvl_d_nxt;
      oen_b_r <= oen_b_nxt;
      oen_d_r <= oen_d_nxt;
    end
  end

  assign ch0_pin_b_o      = lvl_b_r;
  assign ch0_pin_d_o      = lvl_d_r;
  assign ch0_pin_b_oe_n_o = oen_b_r;
  assign ch0_pin_d_oe_n_o = oen_d_r;

  //----------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------
  sequence s_low_write;
    wr_cycle && adr_word == OFF_IO_CTRL_LOW && wb_sel_i[0];
  endsequence

  sequence s_b_rise_cap;
    nib_b == NIB_CAP_RISE && b_s2_r && !b_s3_r;
  endsequence

  sequence s_d_fall_cap;
    !buf_b && nib_d == NIB_CAP_FALL && !d_s2_r && d_s3_r;
  endsequence

  a_low_ctrl_write: assert property (@(posedge clock_i) disable iff (reset_i)
    s_low_write |=> io_low_r == $past(wb_dat_i[7:0]))
    else $error("Low control register did not take written byte");

  a_pin_b_enable: assert property (@(posedge clock_i) disable iff (reset_i)
    ##1 ch0_pin_b_oe_n_o == !$past(!nib_b[3] && nib_b[1:0] != 2'h0))
    else $error("Pin B enable does not follow its nibble");

  a_initial_level: assert property (@(posedge clock_i) disable iff (reset_i)
    (!run && drive_b) |=> ch0_pin_b_o == $past(nib_b[2]))
    else $error("Pin B initial level wrong while stopped");

  a_match_toggle: assert property (@(posedge clock_i) disable iff (reset_i)
    (match_b && nib_b[1:0] == ACT_TOGGLE) |=> ch0_pin_b_o != $past(ch0_pin_b_o))
    else $error("Pin B did not toggle at compare match");

  a_run_hold: assert property (@(posedge clock_i) disable iff (reset_i)
    (run && !match_b) ##1 (run && !match_b) |=> $stable(ch0_pin_b_o) [*1])
    else $error("Pin B moved without compare match while running");

  a_rise_capture: assert property (@(posedge clock_i) disable iff (reset_i)
    s_b_rise_cap |=> greg_b_r == $past(ch0_count_i))
    else $error("Register B missed rising edge capture");

  a_fall_capture_d: assert property (@(posedge clock_i) disable iff (reset_i)
    s_d_fall_cap |=> greg_d_r == $past(ch0_count_i))
    else $error("Register D missed falling edge capture");

  // Triggered by a real channel 1 tick, so a missing prescale gate would show
  a_ch1_refused: assert property (@(posedge clock_i) disable iff (reset_i)
    (nib_b[3:2] == NIB_CAP_CH1 && control_r[CTL_PSC_LSB+2:CTL_PSC_LSB] == PSC_UNDIVIDED
     && ch1_count_tick_i && !wr_cycle) |=> $stable(greg_b_r))
    else $error("Register B captured on undivided channel 1 clock");

  a_buffer_d_off: assert property (@(posedge clock_i) disable iff (reset_i)
    buf_b |=> ch0_pin_d_oe_n_o)
    else $error("Pin D driven while register D is a buffer");

  a_ack_single: assert property (@(posedge clock_i) disable iff (reset_i)
    (wb_cyc_i && wb_stb_i && !ack_r) |=> ack_r ##1 !ack_r)
    else $error("Bus ack not a single cycle one state later");

endmodule : timer_io_control_ch0_bd

`default_nettype wire

// [sim/pin_model.sv]
// Model of the world outside one timer channel pin.
// Assumes the block drives the pin only while its active-low enable is low.
`timescale 1ns/100ps
`default_nettype none

module pin_model (
  input  wire logic oe_n_i,
  input  wire logic drv_i,
  input  wire logic ext_i,
  output logic      pin_o
);
  // Outside source takes the wire once the block lets go, never a stale level
  assign pin_o = oe_n_i ? ext_i : drv_i;
endmodule : pin_model

`default_nettype wire

// [sim/timer_io_control_ch0_bd_tb.sv]
// Self-checking bench for the channel 0 B/D function decode block.
// Assumes the package, the design and pin_model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module timer_io_control_ch0_bd_tb;
  import timer_io_pkg::*;
  logic              clk, rst, cyc, stb, we, tk0, tk1, ext_b, ext_d, lvl;
  logic [7:0]        adr;
  logic [3:0]        sel, nib;
  logic [31:0]       dat, rdat, s, e;
  logic [GREG_W-1:0] cnt;
  wire logic [31:0]  dat_o;
  wire logic         ack, pb_o, pb_oe_n, pd_o, pd_oe_n, pb_i, pd_i;
  int                n_fail, checks;

  //----------------------------------------------------------------
  // Clock, pins and design
  //----------------------------------------------------------------
  always #12.5 clk = ~clk;
  pin_model pmb (.oe_n_i(pb_oe_n), .drv_i(pb_o), .ext_i(ext_b), .pin_o(pb_i));
  pin_model pmd (.oe_n_i(pd_oe_n), .drv_i(pd_o), .ext_i(ext_d), .pin_o(pd_i));
  timer_io_control_ch0_bd uut (.clock_i(clk), .reset_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .ch0_count_i(cnt), .ch0_count_tick_i(tk0), .ch1_count_tick_i(tk1),
    .ch0_pin_b_i(pb_i), .ch0_pin_b_o(pb_o), .ch0_pin_b_oe_n_o(pb_oe_n),
    .ch0_pin_d_i(pd_i), .ch0_pin_d_o(pd_o), .ch0_pin_d_oe_n_o(pd_oe_n));

  //----------------------------------------------------------------
  // Helpers and reference model
  //----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  // Pin level after a compare match for the two action bits
  function automatic logic act(input logic [1:0] a, input logic l);
    return (a == 2'h1) ? 1'b0 : (a == 2'h2) ? 1'b1 : (a == 2'h3) ? ~l : l;
  endfunction : act

  // Classic single cycle; the idle edge at entry keeps requests apart.
  // Ack and read data are taken at the rising edge; only the watchdog ends a wait.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    {cyc, stb, we} <= 3'b000;
  endtask : bus

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (x !== g) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // One-cycle count event on channel 0 or channel 1
  task automatic tick(input logic [15:0] c, input logic ch0);
    @(posedge clk);
    cnt <= c;
    {tk0, tk1} <= {ch0, ~ch0};
    @(posedge clk);
    {tk0, tk1} <= 2'b00;
  endtask : tick

  task automatic pin(input int r, input logic v);
    if (r != 0) ext_d <= v;
    else ext_b <= v;
    repeat (6) @(posedge clk);
  endtask : pin

  task automatic print_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  //----------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------
  initial begin
    clk = 0; rst = 1; {cyc, stb, we, tk0, tk1, ext_b, ext_d} = '0;
    adr = 0; dat = 0; sel = 4'hF; cnt = 0; s = 32'd97095; n_fail = 0; checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    bus(0, OFF_IO_CTRL_LOW, 0);
    chk("io_low_reset", 0, rdat);
    s = lfsr(s);
    bus(1, OFF_IO_CTRL_LOW, s);
    bus(0, OFF_IO_CTRL_LOW, 0);
    chk("io_low_rw", {24'h0, s[7:0]}, rdat);
    bus(1, OFF_IO_CTRL_LOW, 0);
    bus(0, 8'h18, 0);
    chk("unmapped", 0, rdat);
    // Every output compare nibble on B, then on D
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 8; k++) begin
        nib = k[3:0];
        s = lfsr(s);
        bus(1, OFF_CONTROL, 0);
        bus(1, r ? OFF_GREG_D : OFF_GREG_B, {16'h0, s[15:0]});
        bus(1, r ? OFF_IO_CTRL_LOW : OFF_IO_CTRL_HIGH, {24'h0, nib, 4'h0});
        repeat (2) @(posedge clk);
        lvl = nib[2];
        chk("oe_n", nib[1:0] == 2'h0, r ? pd_oe_n : pb_oe_n);
        if (nib[1:0] != 0) chk("initial", lvl, r ? pd_o : pb_o);
        bus(1, OFF_CONTROL, 1);
        tick(s[15:0] + 16'h1, 1);
        tick(s[15:0], 1);
        lvl = act(nib[1:0], lvl);
        repeat (2) @(posedge clk);
        if (nib[1:0] != 0) chk("match", lvl, r ? pd_o : pb_o);
        bus(0, OFF_STATUS, 0);
        chk("status_drv", nib[1:0] != 2'h0, rdat[r ? STAT_DRV_D : STAT_DRV_B]);
        if (nib[1:0] != 0) chk("status_lvl", lvl, rdat[r ? STAT_LVL_D : STAT_LVL_B]);
      end
      bus(1, r ? OFF_IO_CTRL_LOW : OFF_IO_CTRL_HIGH, 0);
    end
    // Pin edge captures, rising then falling, each nibble on B and D
    bus(1, OFF_CONTROL, 0);
    for (int r = 0; r < 2; r++) begin
      for (int k = 8; k < 12; k++) begin
        nib = k[3:0];
        s = lfsr(s);
        e = {16'h0, s[31:16]};
        bus(1, r ? OFF_GREG_D : OFF_GREG_B, e);
        bus(1, r ? OFF_IO_CTRL_LOW : OFF_IO_CTRL_HIGH, {24'h0, nib, 4'h0});
        cnt <= s[15:0];
        pin(r, 1'b1);
        if (nib != 4'h9) e = {16'h0, s[15:0]};
        bus(0, r ? OFF_GREG_D : OFF_GREG_B, 0);
        chk("cap_rise", e, rdat);
        cnt <= ~s[15:0];
        pin(r, 1'b0);
        if (nib != 4'h8) e = {16'h0, ~s[15:0]};
        bus(0, r ? OFF_GREG_D : OFF_GREG_B, 0);
        chk("cap_fall", e, rdat);
      end
      // Channel 1 count capture, undivided prescale first
      for (int p = 0; p < 2; p++) begin
        s = lfsr(s);
        e = {16'h0, s[31:16]};
        bus(1, OFF_CONTROL, p ? 32'h14 : 32'h0);
        bus(1, r ? OFF_GREG_D : OFF_GREG_B, e);
        bus(1, r ? OFF_IO_CTRL_LOW : OFF_IO_CTRL_HIGH, {24'h0, 4'hC, 4'h0});
        tick(s[15:0], 0);
        repeat (3) @(posedge clk);
        if (p != 0) e = {16'h0, s[15:0]};
        bus(0, r ? OFF_GREG_D : OFF_GREG_B, 0);
        chk("cap_ch1", e, rdat);
      end
      bus(1, r ? OFF_IO_CTRL_LOW : OFF_IO_CTRL_HIGH, 0);
    end
    // Buffer mode: register D must ignore its capture nibble
    bus(1, OFF_CONTROL, 32'h2);
    bus(1, OFF_IO_CTRL_LOW, 32'h80);
    bus(0, OFF_GREG_D, 0);
    chk("buffer_d_pre", e, rdat);
    cnt <= ~cnt;
    pin(1, 1'b1);
    bus(0, OFF_GREG_D, 0);
    chk("buffer_d", e, rdat);
    print_verdict();
  end

  // Watchdog: the scenarios need under 1000 cycles, this allows about 4000
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end
endmodule : timer_io_control_ch0_bd_tb

`default_nettype wire
